// [src/tccb_pkg.sv]
package tccb_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam int ADDR_W = 6;
	localparam logic [5:0] OFF_CTRL_A = 6'h00;
	localparam logic [5:0] OFF_CTRL_B = 6'h04;
	localparam logic [5:0] OFF_OWN_ONE = 6'h08;
	localparam logic [5:0] OFF_OWN_TWO = 6'h0c;
	localparam logic [5:0] OFF_TIMING = 6'h10;
	localparam logic [5:0] OFF_TIMEOUT = 6'h14;
	localparam logic [5:0] OFF_STATUS = 6'h18;
	localparam logic [5:0] OFF_FLAG_CLR = 6'h1c;
	localparam logic [5:0] OFF_PEC = 6'h20;
	localparam logic [5:0] OFF_RX = 6'h24;
	localparam logic [5:0] OFF_TX = 6'h28;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_A_WMASK = 32'h00ff_dfff;
	localparam logic [31:0] CTRL_A_LOCK = 32'h0002_1f00;
	localparam logic [31:0] CTRL_A_SMBUS = 32'h00f0_0000;
	localparam logic [31:0] TX_WMASK = 32'h0000_00ff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// Control register A fields
	// ****************************************
	localparam int B_ENABLE = 0;
	localparam int B_TX_IE = 1;
	localparam int B_RX_IE = 2;
	localparam int B_ADDR_IE = 3;
	localparam int B_NACK_IE = 4;
	localparam int B_STOP_IE = 5;
	localparam int B_DONE_IE = 6;
	localparam int B_ERR_IE = 7;
	localparam int B_DNF_LO = 8;
	localparam int B_ANF_OFF = 12;
	localparam int B_DMA_TX = 14;
	localparam int B_DMA_RX = 15;
	localparam int B_SBC = 16;
	localparam int B_NO_STRETCH = 17;
	localparam int B_WAKE = 18;
	localparam int B_GCALL = 19;
	localparam int B_HOST = 20;
	localparam int B_DEFAULT = 21;
	localparam int B_ALERT = 22;
	localparam int B_PEC = 23;

	// ****************************************
	// Status and flag clear fields
	// ****************************************
	localparam int S_TX_EMPTY = 0;
	localparam int S_TX_INT = 1;
	localparam int S_RX_FULL = 2;
	localparam int S_ADDR = 3;
	localparam int S_NACK = 4;
	localparam int S_STOP = 5;
	localparam int S_DONE = 6;
	localparam int S_BERR = 8;
	localparam int S_ARB = 9;
	localparam int S_OVR = 10;
	localparam int S_PECE = 11;
	localparam int S_TOUT = 12;
	localparam int S_ALERT = 13;
	localparam logic [31:0] STICKY_MASK = 32'h0000_3f38;
	localparam logic [31:0] ERR_MASK = 32'h0000_3f00;

	// ****************************************
	// Special addresses, byte form
	// ****************************************
	localparam logic [7:0] GCALL_ADDR = 8'h00;
	localparam logic [7:0] HOST_ADDR_WR = 8'h10;
	localparam logic [7:0] HOST_ADDR_RD = 8'h11;
	localparam logic [7:0] DEF_ADDR_WR = 8'hc2;
	localparam logic [7:0] DEF_ADDR_RD = 8'hc3;

	typedef struct packed {
		logic awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [ADDR_W-1:0] araddr;
		logic rready;
	} tccb_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} tccb_axil_rsp_t;

	typedef struct packed {
		logic controller_enable;
		logic tx_irq_enable;
		logic rx_irq_enable;
		logic addr_match_irq_enable;
		logic nack_irq_enable;
		logic stop_detect_irq_enable;
		logic transfer_done_irq_enable;
		logic error_irq_enable;
		logic [3:0] digital_filter_len;
		logic analog_filter_off;
		logic dma_tx_request_enable;
		logic dma_rx_request_enable;
		logic slave_byte_ctl_enable;
		logic stretch_disable;
		logic stop_wake_enable;
		logic general_call_enable;
		logic host_addr_enable;
		logic default_addr_enable;
		logic alert_enable;
		logic packet_check_enable;
		logic alert_resp_ack_enable;
	} tccb_cfg_t;

	typedef struct packed {
		logic tx_empty;
		logic tx_int;
		logic rx_not_empty;
		logic transfer_done;
		logic addr_match;
		logic nack;
		logic stop;
		logic bus_error;
		logic arb_lost;
		logic overrun;
		logic pec_err;
		logic timeout;
		logic [7:0] rx_data;
		logic [7:0] pec_value;
	} tccb_evt_t;

endpackage : tccb_pkg

// [src/tccb_regbank.sv]
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ns
// Notes on behaviour
// R1 - Bit 0 enables the whole controller
// R2 - Bits 1-6 enable the six event interrupts
// R3 - Bit 7 raises interrupt on any error flag
// R4 - Bits 11:8 set digital filter length, zero off
// R5 - Digital filter adds onto the analog filter
// R6 - Filter and stretch bits locked while enabled
// R7 - Bit 12 set bypasses the analog filter
// R8 - Bits 14/15 enable transmit/receive DMA requests
// R9 - Bit 16 enables slave byte control
// R10 - Bit 17 disables slave clock stretching
// R11 - Bit 18 enables wake from stop mode
// R12 - Bit 19 answers general call address 0x00
// R13 - Bit 20 answers host address 0x10/0x11
// R14 - Bit 21 answers default address 0xC2/0xC3
// R15 - Device mode alert drives pin low, acks
// R16 - Host mode alert enables alert input
// R17 - Without SMBus, bits 20-23 read zero
// R18 - Bit 23 enables packet error checking
// R19 - Eleven word registers from 0x00 to 0x28
// R20 - Nonzero filter length cancels stop wake
// R21 - Bus error sets flag, may interrupt
// R22 - Bit 13 and 31:24 read zero
module tccb_regbank #(
	parameter bit SMBUS_SUPPORT = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register bus
	input wire tccb_pkg::tccb_axil_req_t bus_req,
	output tccb_pkg::tccb_axil_rsp_t bus_rsp,
	// Protocol engine side
	input wire tccb_pkg::tccb_evt_t evt,
	output tccb_pkg::tccb_cfg_t cfg,
	output logic [31:0] status,
	output logic [31:0] ctrl_b,
	output logic [31:0] own_one,
	output logic [31:0] own_two,
	output logic [31:0] timing,
	output logic [31:0] timeout,
	output logic [7:0] tx_data,
	output logic tx_write_pulse,
	output logic rx_read_pulse,
	output logic irq,
	// Address probe
	input wire logic [7:0] addr_byte,
	output logic special_hit,
	// Bus line inputs and filtered levels
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_filtered,
	output logic sda_filtered,
	// Alert pin, open drain
	input wire logic alert_pin_i,
	output logic alert_pin_o,
	output logic alert_pin_oe
);
	import tccb_pkg::*;

	typedef struct packed {
		logic awready;
		logic wready;
		logic arready;
		logic aw_got;
		logic w_got;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [31:0] ctrl_a;
		logic [31:0] ctrl_b;
		logic [31:0] own_one;
		logic [31:0] own_two;
		logic [31:0] timing;
		logic [31:0] timeout;
		logic [7:0] tx_data;
		logic [31:0] flags;
		logic tx_write;
		logic rx_read;
		logic irq;
		logic special_hit;
		logic [1:0] line_s1;
		logic [1:0] line_s2;
		logic [1:0] line_flt;
		logic [1:0][3:0] flt_cnt;
		logic alert_s1;
		logic alert_s2;
		logic alert_s3;
		logic alert_oe;
		tccb_cfg_t cfg;
	} tccb_state_t;

	tccb_state_t st;
	tccb_state_t nx;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
		logic hit;
		hit = 1'b0;
		if (a[1:0] != 2'h0)
		begin
			hit = 1'b0;
		end
		else if (a <= OFF_TX)
		begin
			hit = 1'b1; // [R19]
		end
		return hit;
	endfunction : is_mapped

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
			begin
				res[b*8 +: 8] = data[b*8 +: 8];
			end
		end
		return res;
	endfunction : merge

	function automatic logic [31:0] status_word(input logic [31:0] flags, input tccb_evt_t e);
		logic [31:0] w;
		w = flags & STICKY_MASK;
		w[S_TX_EMPTY] = e.tx_empty;
		w[S_TX_INT] = e.tx_int;
		w[S_RX_FULL] = e.rx_not_empty;
		w[S_DONE] = e.transfer_done;
		return w;
	endfunction : status_word

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		logic [31:0] set_vec;
		logic [31:0] clr_vec;
		logic [31:0] new_a;
		logic [31:0] stat;
		logic [ADDR_W-1:0] wa;
		logic [ADDR_W-1:0] ra;
		logic host_mode;
		set_vec = '0;
		clr_vec = '0;
		new_a = st.ctrl_a;
		stat = status_word(st.flags, evt);
		wa = st.awaddr;
		ra = bus_req.araddr;
		host_mode = st.cfg.host_addr_enable;
		nx = st;
		nx.tx_write = 1'b0;
		nx.rx_read = 1'b0;

		// Two-stage synchronisers; stage one feeds stage two only
		nx.line_s1 = {sda_in, scl_in};
		nx.line_s2 = st.line_s1;
		nx.alert_s1 = alert_pin_i;
		nx.alert_s2 = st.alert_s1;
		nx.alert_s3 = st.alert_s2;

		// Digital glitch filter; the analog stage sits in front of the pins, so this adds
		// its delay on top of it rather than replacing it [R5]
		for (int i = 0; i < 2; i++)
		begin
			if (st.cfg.digital_filter_len == 4'h0)
			begin
				nx.line_flt[i] = st.line_s2[i]; // [R4]
				nx.flt_cnt[i] = 4'h0;
			end
			else if (st.line_s2[i] == st.line_flt[i])
			begin
				nx.flt_cnt[i] = 4'h0;
			end
			else if (st.flt_cnt[i] + 4'h1 >= st.cfg.digital_filter_len)
			begin
				nx.line_flt[i] = st.line_s2[i]; // [R4]
				nx.flt_cnt[i] = 4'h0;
			end
			else
			begin
				nx.flt_cnt[i] = st.flt_cnt[i] + 4'h1;
			end
		end

		// ****************************************
		// Write channel
		// ****************************************
		if (st.awready && bus_req.awvalid)
		begin
			nx.awaddr = bus_req.awaddr;
			nx.aw_got = 1'b1;
		end
		if (st.wready && bus_req.wvalid)
		begin
			nx.wdata = bus_req.wdata;
			nx.wstrb = bus_req.wstrb;
			nx.w_got = 1'b1;
		end
		if (st.aw_got && st.w_got && !st.bvalid)
		begin
			nx.aw_got = 1'b0;
			nx.w_got = 1'b0;
			nx.bvalid = 1'b1;
			nx.bresp = is_mapped(wa) ? RESP_OKAY : RESP_SLVERR;
			if (wa == OFF_CTRL_A)
			begin
				new_a = merge(st.ctrl_a, st.wdata, st.wstrb) & CTRL_A_WMASK; // [R22]
				if (!SMBUS_SUPPORT)
				begin
					new_a = new_a & ~CTRL_A_SMBUS; // [R17]
				end
				if (st.ctrl_a[B_ENABLE])
				begin
					new_a = (new_a & ~CTRL_A_LOCK) | (st.ctrl_a & CTRL_A_LOCK); // [R6]
				end
				nx.ctrl_a = new_a;
			end
			else if (wa == OFF_CTRL_B)
			begin
				nx.ctrl_b = merge(st.ctrl_b, st.wdata, st.wstrb);
			end
			else if (wa == OFF_OWN_ONE)
			begin
				nx.own_one = merge(st.own_one, st.wdata, st.wstrb);
			end
			else if (wa == OFF_OWN_TWO)
			begin
				nx.own_two = merge(st.own_two, st.wdata, st.wstrb);
			end
			else if (wa == OFF_TIMING)
			begin
				nx.timing = merge(st.timing, st.wdata, st.wstrb);
			end
			else if (wa == OFF_TIMEOUT)
			begin
				nx.timeout = merge(st.timeout, st.wdata, st.wstrb);
			end
			else if (wa == OFF_FLAG_CLR)
			begin
				clr_vec = merge(32'h0000_0000, st.wdata, st.wstrb) & STICKY_MASK;
			end
			else if (wa == OFF_TX && st.wstrb[0])
			begin
				nx.tx_data = st.wdata[7:0] & TX_WMASK[7:0];
				nx.tx_write = 1'b1;
			end
		end
		if (st.bvalid && bus_req.bready)
		begin
			nx.bvalid = 1'b0;
		end
		nx.awready = !nx.aw_got && !nx.bvalid;
		nx.wready = !nx.w_got && !nx.bvalid;

		// ****************************************
		// Read channel
		// ****************************************
		if (st.arready && bus_req.arvalid)
		begin
			nx.rvalid = 1'b1;
			nx.rresp = is_mapped(ra) ? RESP_OKAY : RESP_SLVERR;
			nx.rdata = 32'h0000_0000;
			if (ra == OFF_CTRL_A)
			begin
				nx.rdata = st.ctrl_a;
			end
			else if (ra == OFF_CTRL_B)
			begin
				nx.rdata = st.ctrl_b;
			end
			else if (ra == OFF_OWN_ONE)
			begin
				nx.rdata = st.own_one;
			end
			else if (ra == OFF_OWN_TWO)
			begin
				nx.rdata = st.own_two;
			end
			else if (ra == OFF_TIMING)
			begin
				nx.rdata = st.timing;
			end
			else if (ra == OFF_TIMEOUT)
			begin
				nx.rdata = st.timeout;
			end
			else if (ra == OFF_STATUS)
			begin
				nx.rdata = stat;
			end
			else if (ra == OFF_PEC)
			begin
				nx.rdata = {24'h00_0000, evt.pec_value};
			end
			else if (ra == OFF_RX)
			begin
				nx.rdata = {24'h00_0000, evt.rx_data};
				nx.rx_read = 1'b1;
			end
			else if (ra == OFF_TX)
			begin
				nx.rdata = {24'h00_0000, st.tx_data};
			end
		end
		if (st.rvalid && bus_req.rready)
		begin
			nx.rvalid = 1'b0;
		end
		nx.arready = !nx.rvalid;

		// ****************************************
		// Sticky flags: a set in the clearing cycle wins
		// ****************************************
		set_vec[S_ADDR] = evt.addr_match;
		set_vec[S_NACK] = evt.nack;
		set_vec[S_STOP] = evt.stop;
		set_vec[S_BERR] = evt.bus_error; // [R21]
		set_vec[S_ARB] = evt.arb_lost;
		set_vec[S_OVR] = evt.overrun;
		set_vec[S_PECE] = evt.pec_err;
		set_vec[S_TOUT] = evt.timeout;
		// Host side alert: falling edge on the synchronised pin [R16]
		set_vec[S_ALERT] = host_mode && st.cfg.alert_enable && st.alert_s3 && !st.alert_s2;
		nx.flags = ((st.flags & ~clr_vec) | set_vec) & STICKY_MASK;

		// Interrupt from the flags already visible in status
		nx.irq = (st.cfg.tx_irq_enable && stat[S_TX_INT]) // [R2]
			|| (st.cfg.rx_irq_enable && stat[S_RX_FULL])
			|| (st.cfg.addr_match_irq_enable && stat[S_ADDR])
			|| (st.cfg.nack_irq_enable && stat[S_NACK])
			|| (st.cfg.stop_detect_irq_enable && stat[S_STOP])
			|| (st.cfg.transfer_done_irq_enable && stat[S_DONE])
			|| (st.cfg.error_irq_enable && (|(stat & ERR_MASK))); // [R3] [R21]

		// ****************************************
		// Configuration seen by the protocol engine
		// ****************************************
		nx.cfg.controller_enable = nx.ctrl_a[B_ENABLE]; // [R1]
		nx.cfg.tx_irq_enable = nx.ctrl_a[B_TX_IE]; // [R2]
		nx.cfg.rx_irq_enable = nx.ctrl_a[B_RX_IE];
		nx.cfg.addr_match_irq_enable = nx.ctrl_a[B_ADDR_IE];
		nx.cfg.nack_irq_enable = nx.ctrl_a[B_NACK_IE];
		nx.cfg.stop_detect_irq_enable = nx.ctrl_a[B_STOP_IE];
		nx.cfg.transfer_done_irq_enable = nx.ctrl_a[B_DONE_IE];
		nx.cfg.error_irq_enable = nx.ctrl_a[B_ERR_IE]; // [R3]
		nx.cfg.digital_filter_len = nx.ctrl_a[B_DNF_LO +: 4]; // [R4]
		nx.cfg.analog_filter_off = nx.ctrl_a[B_ANF_OFF]; // [R7]
		nx.cfg.dma_tx_request_enable = nx.ctrl_a[B_DMA_TX]; // [R8]
		nx.cfg.dma_rx_request_enable = nx.ctrl_a[B_DMA_RX]; // [R8]
		nx.cfg.slave_byte_ctl_enable = nx.ctrl_a[B_SBC]; // [R9]
		// Engine applies this only while acting as slave
		nx.cfg.stretch_disable = nx.ctrl_a[B_NO_STRETCH]; // [R10]
		// Wake-up needs the digital filter off; the bit stays readable though
		nx.cfg.stop_wake_enable = nx.ctrl_a[B_WAKE]
			&& (nx.ctrl_a[B_DNF_LO +: 4] == 4'h0); // [R11] [R20]
		nx.cfg.general_call_enable = nx.ctrl_a[B_GCALL]; // [R12]
		nx.cfg.host_addr_enable = nx.ctrl_a[B_HOST]; // [R13]
		nx.cfg.default_addr_enable = nx.ctrl_a[B_DEFAULT]; // [R14]
		nx.cfg.alert_enable = nx.ctrl_a[B_ALERT]; // [R15] [R16]
		nx.cfg.packet_check_enable = nx.ctrl_a[B_PEC]; // [R18]
		nx.cfg.alert_resp_ack_enable = nx.ctrl_a[B_ALERT] && !nx.ctrl_a[B_HOST]; // [R15]

		// Device mode alert pulls the pin low; otherwise it is released
		nx.alert_oe = nx.ctrl_a[B_ALERT] && !nx.ctrl_a[B_HOST]; // [R15]

		// Special slave addresses, checked on the byte with its direction bit
		nx.special_hit = (st.cfg.general_call_enable && addr_byte == GCALL_ADDR) // [R12]
			|| (st.cfg.host_addr_enable
			&& (addr_byte == HOST_ADDR_WR || addr_byte == HOST_ADDR_RD)) // [R13]
			|| (st.cfg.default_addr_enable
			&& (addr_byte == DEF_ADDR_WR || addr_byte == DEF_ADDR_RD)); // [R14]
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st <= '0;
		end
		else
		begin
			st <= nx;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign bus_rsp.awready = st.awready;
	assign bus_rsp.wready = st.wready;
	assign bus_rsp.bvalid = st.bvalid;
	assign bus_rsp.bresp = st.bresp;
	assign bus_rsp.arready = st.arready;
	assign bus_rsp.rvalid = st.rvalid;
	assign bus_rsp.rdata = st.rdata;
	assign bus_rsp.rresp = st.rresp;
	assign cfg = st.cfg;
	assign status = st.flags;
	assign ctrl_b = st.ctrl_b;
	assign own_one = st.own_one;
	assign own_two = st.own_two;
	assign timing = st.timing;
	assign timeout = st.timeout;
	assign tx_data = st.tx_data;
	assign tx_write_pulse = st.tx_write;
	assign rx_read_pulse = st.rx_read;
	assign irq = st.irq;
	assign special_hit = st.special_hit;
	assign scl_filtered = st.line_flt[0];
	assign sda_filtered = st.line_flt[1];
	assign alert_pin_o = 1'b0;
	assign alert_pin_oe = st.alert_oe;

endmodule : tccb_regbank

// [verif/tccb_bus_agent.sv]
`timescale 1ns/1ns
module tccb_bus_agent (
	// Clock
	input wire logic clk,
	// Alert pin of the block
	input wire logic alert_pin_o,
	input wire logic alert_pin_oe,
	// Line levels seen by the block
	output logic scl,
	output logic sda,
	output logic alert
);
	logic alert_low;
	initial
	begin
		scl = 1'h1;
		sda = 1'h1;
		alert_low = 1'h0;
	end
	// Pulled-up line, so it only reads low while some party pulls it
	assign alert = !(alert_low || (alert_pin_oe && !alert_pin_o));
	// Another device asking the host for attention
	task automatic raise_alert(input int n);
		@(posedge clk);
		alert_low <= 1'h1;
		repeat (n) @(posedge clk);
		alert_low <= 1'h0;
	endtask : raise_alert
	// Short holds act as glitches, long ones as real clock lows
	task automatic scl_low(input int n);
		@(posedge clk);
		scl <= 1'h0;
		repeat (n) @(posedge clk);
		scl <= 1'h1;
	endtask : scl_low
endmodule : tccb_bus_agent

// [verif/tccb_regbank_assertions.sv]
`timescale 1ns/1ns
module tccb_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Watched ports
	input wire tccb_pkg::tccb_axil_req_t bus_req,
	input wire tccb_pkg::tccb_axil_rsp_t bus_rsp,
	input wire tccb_pkg::tccb_evt_t evt,
	input wire tccb_pkg::tccb_cfg_t cfg,
	input wire logic [31:0] status,
	input wire logic irq,
	input wire logic [7:0] addr_byte,
	input wire logic special_hit,
	input wire logic scl_in,
	input wire logic scl_filtered,
	input wire logic alert_pin_o,
	input wire logic alert_pin_oe
);
	import tccb_pkg::*;
	logic ar_go;
	logic ar_bad;
	logic hit;
	logic cause;
	assign ar_go = bus_req.arvalid && bus_rsp.arready;
	assign ar_bad = bus_req.araddr[1:0] != 2'h0 || bus_req.araddr > OFF_TX;
	assign hit = (addr_byte == GCALL_ADDR && cfg.general_call_enable)
		|| (addr_byte[7:1] == HOST_ADDR_WR[7:1] && cfg.host_addr_enable)
		|| (addr_byte[7:1] == DEF_ADDR_WR[7:1] && cfg.default_addr_enable);
	// Levels come live from the engine, pulses only count once sticky
	assign cause = (evt.tx_int && cfg.tx_irq_enable) || (evt.rx_not_empty && cfg.rx_irq_enable)
		|| (evt.transfer_done && cfg.transfer_done_irq_enable)
		|| (|status[13:8] && cfg.error_irq_enable) || |(status[5:3]
		& {cfg.stop_detect_irq_enable, cfg.nack_irq_enable, cfg.addr_match_irq_enable});
	// ********
	// Checks
	// ********
	default clocking dc @(posedge clk); endclocking
	default disable iff (!rstn);
	field_lock_a: assert property ($past(cfg.controller_enable)
		|-> $stable({cfg.digital_filter_len, cfg.analog_filter_off, cfg.stretch_disable}))
		else $error("locked field moved");
	wake_mask_a: assert property (cfg.stop_wake_enable |-> cfg.digital_filter_len == 4'h0)
		else $error("wake with filter");
	alert_pin_a: assert property ($stable(cfg.alert_enable && !cfg.host_addr_enable)
		|-> alert_pin_oe == (cfg.alert_enable && !cfg.host_addr_enable) && !alert_pin_o)
		else $error("alert pin");
	addr_hit_a: assert property (1 |=> special_hit == $past(hit))
		else $error("special address");
	err_irq_a: assert property (cfg.error_irq_enable && |status[13:8] |-> ##[1:2] irq)
		else $error("error irq missing");
	quiet_irq_a: assert property (!cause [*2] |=> !irq)
		else $error("irq without cause");
	ctrl_rsv_a: assert property (ar_go && bus_req.araddr == OFF_CTRL_A
		|=> bus_rsp.rvalid && bus_rsp.rdata[31:24] == 8'h00 && !bus_rsp.rdata[13])
		else $error("reserved bits");
	bad_addr_a: assert property (ar_go && ar_bad |=> bus_rsp.rresp == RESP_SLVERR)
		else $error("unmapped read");
	filt_off_a: assert property ((cfg.digital_filter_len == 4'h0 && $stable(scl_in)) [*5]
		|-> scl_filtered == scl_in)
		else $error("filtered clock");
	cover property (irq);
	cover property (special_hit);
	cover property (ar_go && ar_bad);
endmodule : tccb_chk
bind tccb_regbank tccb_chk u_tccb_chk (.clk, .rstn, .bus_req, .bus_rsp, .evt, .cfg, .status,
	.irq, .addr_byte, .special_hit, .scl_in, .scl_filtered, .alert_pin_o, .alert_pin_oe);

// [verif/test_twowire_control_config_bank.sv]
`timescale 1ns/1ns
module test_twowire_control_config_bank;
	import tccb_pkg::*;
	typedef struct packed {
		logic [5:0] addr;
		logic [31:0] wdata;
		logic [31:0] rdata;
		logic [1:0] resp;
	} tccb_row_t;
	logic clk;
	logic rstn;
	tccb_axil_req_t req;
	tccb_axil_rsp_t rsp;
	tccb_evt_t evt;
	tccb_cfg_t cfg;
	logic [31:0] status;
	logic [7:0] tx_data;
	logic irq;
	logic [7:0] addr_byte;
	logic special_hit;
	logic scl;
	logic sda;
	logic scl_f;
	logic sda_f;
	logic [31:0] regs_o [5];
	logic [1:0] pulse;
	int n_tx;
	int n_rx;
	tccb_cfg_t cfg_lite;
	logic alert;
	logic alert_o;
	logic alert_oe;
	logic [1:0] resp;
	logic [31:0] rd;
	int n_errors;
	int compares;
	tccb_row_t rows [14];
	int st_bit [11] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 12};
	// Bit of each cause inside the packed event bundle
	int ev_pos [11] = '{26, 25, 23, 22, 21, 24, 20, 19, 18, 17, 16};
	logic [7:0] hit_addr [6] = '{8'h00, 8'h10, 8'h11, 8'hc2, 8'hc3, 8'h12};
	tccb_regbank u_tccb_regbank (.clk(clk), .rstn(rstn), .bus_req(req), .bus_rsp(rsp),
		.evt(evt), .cfg(cfg), .status(status), .ctrl_b(regs_o[0]), .own_one(regs_o[1]),
		.own_two(regs_o[2]), .timing(regs_o[3]), .timeout(regs_o[4]), .tx_data(tx_data),
		.tx_write_pulse(pulse[0]), .rx_read_pulse(pulse[1]), .irq(irq),
		.addr_byte(addr_byte), .special_hit(special_hit), .scl_in(scl), .sda_in(sda),
		.scl_filtered(scl_f), .sda_filtered(sda_f), .alert_pin_i(alert),
		.alert_pin_o(alert_o), .alert_pin_oe(alert_oe));
	// Variant without the SMBus extras, fed in lockstep; only its configuration is checked
	tccb_regbank #(.SMBUS_SUPPORT(1'b0)) u_tccb_regbank_lite (.clk(clk), .rstn(rstn),
		.bus_req(req), .bus_rsp(), .evt(evt), .cfg(cfg_lite), .status(), .ctrl_b(),
		.own_one(), .own_two(), .timing(), .timeout(), .tx_data(), .tx_write_pulse(),
		.rx_read_pulse(), .irq(), .addr_byte(addr_byte), .special_hit(), .scl_in(scl),
		.sda_in(sda), .scl_filtered(), .sda_filtered(), .alert_pin_i(alert), .alert_pin_o(),
		.alert_pin_oe());
	// Counts register-side strobes so the table can check them once
	always @(posedge clk)
	begin
		n_tx <= n_tx + int'(pulse[0]);
		n_rx <= n_rx + int'(pulse[1]);
	end
	tccb_bus_agent u_tccb_bus_agent (.clk(clk), .alert_pin_o(alert_o), .alert_pin_oe(alert_oe),
		.scl(scl), .sda(sda), .alert(alert));
	initial clk = 1'h0;
	always #4 clk = ~clk;
	// ********
	// Bus and check tasks
	// ********
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (rsp.awready)
				req.awvalid <= 1'h0;
			if (rsp.wready)
				req.wvalid <= 1'h0;
		end
		while (rsp.bvalid !== 1'h1);
		resp = rsp.bresp;
		req.bready <= 1'h0;
	endtask : wr
	task automatic rd_reg(input logic [5:0] a);
		@(posedge clk);
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		do
		begin
			@(posedge clk);
			if (rsp.arready)
				req.arvalid <= 1'h0;
		end
		while (rsp.rvalid !== 1'h1);
		rd = rsp.rdata;
		resp = rsp.rresp;
		req.rready <= 1'h0;
	endtask : rd_reg
	task automatic do_reset;
		rstn <= 1'h0;
		repeat (8) @(posedge clk);
		chk(32'(cfg), 32'h0, "cfg in reset");
		chk(32'(rsp.awready), 32'h0, "ready in reset");
		rstn <= 1'h1;
		rd_reg(OFF_CTRL_A);
		chk(rd, REG_RESET, "reset value");
	endtask : do_reset
	task automatic stop_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : stop_test
	initial
	begin
		#100000;
		n_errors++;
		stop_test;
	end
	// ********
	// Main sequence
	// ********
	initial
	begin
		rstn = 1'h0;
		req = '0;
		evt = '0;
		addr_byte = 8'h00;
		n_errors = 0;
		compares = 0;
		rows = '{
			'{OFF_CTRL_A, 32'hffff_ffff, 32'h00ff_dfff, RESP_OKAY},
			'{OFF_CTRL_A, 32'h0000_0000, 32'h0002_1f00, RESP_OKAY},
			'{OFF_CTRL_A, 32'h0000_0000, 32'h0000_0000, RESP_OKAY},
			'{OFF_CTRL_B, 32'ha5a5_5a5a, 32'ha5a5_5a5a, RESP_OKAY},
			'{OFF_OWN_ONE, 32'h1234_5678, 32'h1234_5678, RESP_OKAY},
			'{OFF_OWN_TWO, 32'h8765_4321, 32'h8765_4321, RESP_OKAY},
			'{OFF_TIMING, 32'hdead_beef, 32'hdead_beef, RESP_OKAY},
			'{OFF_TIMEOUT, 32'h0f0f_f0f0, 32'h0f0f_f0f0, RESP_OKAY},
			'{OFF_STATUS, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY},
			'{OFF_FLAG_CLR, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY},
			'{OFF_RX, 32'hffff_ffff, 32'h0000_0000, RESP_OKAY},
			'{OFF_TX, 32'h1234_56ab, 32'h0000_00ab, RESP_OKAY},
			'{6'h2c, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR},
			'{6'h06, 32'h0000_0000, 32'h0000_0000, RESP_SLVERR}};
		do_reset;
		$display("test reset done");
		foreach (rows[i])
		begin
			wr(rows[i].addr, rows[i].wdata);
			chk(32'(resp), 32'(rows[i].resp), "bresp");
			rd_reg(rows[i].addr);
			chk(32'(resp), 32'(rows[i].resp), "rresp");
			if (rows[i].resp == RESP_OKAY)
				chk(rd, rows[i].rdata, "rdata");
		end
		chk(32'(tx_data), 32'h0000_00ab, "tx byte");
		foreach (regs_o[j])
			chk(regs_o[j], rows[j + 3].rdata, "register out");
		chk(32'(n_tx), 32'h1, "tx strobe");
		chk(32'(n_rx), 32'h1, "rx strobe");
		$display("test register table done");
		wr(OFF_CTRL_A, 32'h0004_0100);
		chk(32'(cfg.stop_wake_enable), 32'h0, "wake masked");
		wr(OFF_CTRL_A, 32'h0004_0000);
		chk(32'(cfg.stop_wake_enable), 32'h1, "wake");
		$display("test wake done");
		foreach (st_bit[k])
		begin
			wr(OFF_CTRL_A, 32'h0);
			evt[ev_pos[k]] <= 1'h1;
			repeat (3) @(posedge clk);
			chk(32'(irq), 32'h0, "masked irq");
			wr(OFF_CTRL_A, 32'(32'h1 << (st_bit[k] > 7 ? 7 : st_bit[k])));
			repeat (3) @(posedge clk);
			chk(32'(irq), 32'h1, "irq");
			chk(status, STICKY_MASK & (32'h1 << st_bit[k]), "flag");
			evt[ev_pos[k]] <= 1'h0;
			wr(OFF_FLAG_CLR, 32'h1 << st_bit[k]);
			repeat (3) @(posedge clk);
			chk(32'(irq), 32'h0, "cleared irq");
		end
		$display("test events done");
		for (int on = 0; on < 4; on++)
		begin
			wr(OFF_CTRL_A, on != 0 ? 32'h1 << (18 + on) : 32'h0);
			foreach (hit_addr[k])
			begin
				addr_byte <= hit_addr[k];
				repeat (2) @(posedge clk);
				chk(32'(special_hit), 32'(k < 5 && on == (k + 3) / 2), "hit");
			end
		end
		$display("test addresses done");
		wr(OFF_CTRL_A, 32'h00f3_d000);
		chk(32'(cfg), 32'h0000_0f9e, "field map");
		chk(32'(cfg_lite), 32'h0000_0f80, "no smbus");
		wr(OFF_CTRL_A, 32'h0040_0000);
		repeat (3) @(posedge clk);
		chk(32'(alert), 32'h0, "alert low");
		wr(OFF_CTRL_A, 32'h0050_0080);
		repeat (3) @(posedge clk);
		chk(32'(alert), 32'h1, "alert free");
		u_tccb_bus_agent.raise_alert(3);
		repeat (6) @(posedge clk);
		chk(32'(status[S_ALERT]), 32'h1, "alert flag");
		chk(32'(irq), 32'h1, "alert irq");
		wr(OFF_FLAG_CLR, 32'h0000_2000);
		$display("test alert done");
		wr(OFF_CTRL_A, 32'h0000_0400);
		fork
			u_tccb_bus_agent.scl_low(3);
			repeat (8)
			begin
				@(posedge clk);
				chk(32'(scl_f), 32'h1, "glitch passed");
			end
		join
		fork
			u_tccb_bus_agent.scl_low(12);
			begin
				repeat (11) @(posedge clk);
				chk(32'(scl_f), 32'h0, "filtered low");
			end
		join
		chk(32'(sda_f), 32'h1, "sda level");
		$display("test filter done");
		do_reset;
		$display("test second reset done");
		stop_test;
	end
endmodule : test_twowire_control_config_bank
